// ==== dv/cmrd_ref_gen_asserts.sv ====
// Port-level assertions for the clock monitor reference generator.
`timescale 1ns/1ps
module cmrd_ref_gen_asserts (
    input wire logic clock_i,            // Clock.
    input wire logic rst_n_i,            // Reset, active low.
    input wire logic ext_clk_i,          // External clock.
    input wire logic base_clk_i,         // Base clock.
    input wire logic int_gen_on_i,       // Internal generator on.
    input wire logic ext_gen_on_i,       // External generator on.
    input wire logic ext_gen_enable_i,   // External enable.
    input wire logic slow_crystal_sel_i, // Slow crystal.
    input wire logic crystal_enable_i,   // Crystal enable.
    input wire logic monitor_on_i,       // Monitor on.
    input wire logic ext_ref_o,          // External reference.
    input wire logic int_ref_o,          // Internal reference.
    input wire logic stab_clk_o,         // Stabilization clock.
    input wire logic ext_stable_o,       // Stable flag.
    input wire logic ext_inactive_o      // Inactive flag.
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_int_off;
        !int_gen_on_i [*3] |-> !int_ref_o;
    endproperty
    a_int_off: assert property (p_int_off) else $error("int ref runs while off");
    property p_ext_off;
        (!ext_gen_on_i && !ext_stable_o) [*3] |-> !ext_ref_o && !stab_clk_o;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("ext side runs while off");
    property p_unst;
        !ext_stable_o [*3] |-> !ext_ref_o;
    endproperty
    a_unst: assert property (p_unst) else $error("ext ref runs while unstable");
    property p_en_flag;
        !ext_gen_enable_i |=> !ext_stable_o;
    endproperty
    a_en_flag: assert property (p_en_flag) else $error("stable kept without enable");
    property p_en_cnt;
        !ext_gen_enable_i [*3] |-> !stab_clk_o;
    endproperty
    a_en_cnt: assert property (p_en_cnt) else $error("long divider runs without enable");
    property p_set;
        $rose(ext_stable_o) |-> stab_clk_o ##1 !stab_clk_o;
    endproperty
    a_set: assert property (p_set) else $error("stable set off a stab falling edge");
    property p_keep;
        $fell(ext_stable_o) |-> !$past(ext_gen_enable_i) || $past(ext_inactive_o);
    endproperty
    a_keep: assert property (p_keep) else $error("stable cleared without cause");
    property p_off_rise;
        $rose(ext_inactive_o) |-> $rose(int_ref_o);
    endproperty
    a_off_rise: assert property (p_off_rise) else $error("inactive set off an int ref rise");
    property p_mon;
        !monitor_on_i [*3] |-> !ext_inactive_o;
    endproperty
    a_mon: assert property (p_mon) else $error("inactive set with monitor off");
    c_stable: cover property ($rose(ext_stable_o));
    c_inact: cover property ($rose(ext_inactive_o));
    c_slow: cover property (ext_stable_o && slow_crystal_sel_i && $rose(int_ref_o));
endmodule

bind cmrd_ref_gen cmrd_ref_gen_asserts u_chk (.clock_i, .rst_n_i, .ext_clk_i, .base_clk_i, .int_gen_on_i,
    .ext_gen_on_i, .ext_gen_enable_i, .slow_crystal_sel_i, .crystal_enable_i, .monitor_on_i, .ext_ref_o,
    .int_ref_o, .stab_clk_o, .ext_stable_o, .ext_inactive_o);

// ==== dv/cmrd_ref_gen_tb.sv ====
// Self-checking bench for the clock monitor reference generator.
`timescale 1ns/1ps
module cmrd_ref_gen_tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic int_on = 1'b1;
    logic ext_on = 1'b0;
    logic ext_en = 1'b0;
    logic slow = 1'b0;
    logic xtal = 1'b0;
    logic mon = 1'b0;
    logic ext_run = 1'b1;
    logic ext_q = 1'b0;
    logic base_q = 1'b0;
    logic ext_clk, base_clk, ext_ref, int_ref, stab_clk, ext_stable, ext_inactive;
    logic [4:0] obs;
    int ext_tk = 0;
    int base_tk = 0;
    int cycles = 0;
    int err_count = 0;
    int compares = 0;

    assign obs = {ext_inactive, ext_stable, stab_clk, int_ref, ext_ref};
    always #25 clock_i = ~clock_i;

    cmrd_src_model src (.ext_run_i(ext_run), .ext_clk_o(ext_clk), .base_clk_o(base_clk));
    cmrd_ref_gen dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ext_clk_i(ext_clk), .base_clk_i(base_clk),
        .int_gen_on_i(int_on), .ext_gen_on_i(ext_on), .ext_gen_enable_i(ext_en), .slow_crystal_sel_i(slow),
        .crystal_enable_i(xtal), .monitor_on_i(mon), .ext_ref_o(ext_ref), .int_ref_o(int_ref),
        .stab_clk_o(stab_clk), .ext_stable_o(ext_stable), .ext_inactive_o(ext_inactive));

    // Source falling edges are counted as the design samples them.
    always @(posedge clock_i)
    begin
        ext_q <= ext_clk;
        base_q <= base_clk;
        ext_tk <= ext_tk + int'(ext_q && !ext_clk);
        base_tk <= base_tk + int'(base_q && !base_clk);
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clock_i);
            #1;
        end
    endtask

    task automatic wait_lvl(input int sel, input logic lvl, output int et, output int bt);
        int n;
        n = 0;
        while (obs[sel] !== lvl && n < 40000)
        begin
            cyc(1);
            n++;
        end
        et = ext_tk;
        bt = base_tk;
    endtask

    task automatic period(input int sel, output int de, output int db);
        int e0, b0, e1, b1;
        wait_lvl(sel, 1'b0, e0, b0);
        wait_lvl(sel, 1'b1, e0, b0);
        wait_lvl(sel, 1'b0, e1, b1);
        wait_lvl(sel, 1'b1, e1, b1);
        de = e1 - e0;
        db = b1 - b0;
    endtask

    task automatic watch(input logic [4:0] mask, output logic seen);
        seen = 1'b0;
        repeat (200)
        begin
            cyc(1);
            seen = seen | (|(obs & mask));
        end
    endtask

    task automatic t_stab(input logic s, input logic x);
        int e0, e1, b;
        ext_en = 1'b0;
        ext_on = 1'b0;
        slow = s;
        xtal = x;
        cyc(4);
        check("stable when off", ext_stable, 1'b0);
        ext_en = 1'b1;
        ext_on = 1'b1;
        e0 = ext_tk;
        wait_lvl(3, 1'b1, e1, b);
        check("stab ticks", e1 - e0, x ? 32'h1000 : 32'h10);
    endtask

    task automatic t_fast();
        int de, db;
        period(0, de, db);
        check("ext ref fast", de, 32'h200);
        period(1, de, db);
        check("int ref fast", db, 32'h4);
        period(2, de, db);
        check("stab when stable", de, 32'h10);
    endtask

    task automatic t_inact();
        int e0, e1, b;
        mon = 1'b1;
        cyc(100);
        check("inactive running", ext_inactive, 1'b0);
        ext_run = 1'b0;
        wait_lvl(4, 1'b1, e1, b);
        cyc(2);
        check("stable dropped", ext_stable, 1'b0);
        mon = 1'b0;
        cyc(3);
        check("inactive released", ext_inactive, 1'b0);
        check("ext ref reverted", ext_ref, 1'b0);
        e0 = ext_tk;
        ext_run = 1'b1;
        wait_lvl(3, 1'b1, e1, b);
        check("restab ticks", e1 - e0, 32'h10);
    endtask

    task automatic t_slow();
        int de, db;
        period(0, de, db);
        check("ext ref slow", de, 32'h4);
        period(1, de, db);
        check("int ref slow", db, 32'h40);
        xtal = 1'b0;
        period(2, de, db);
        check("stab on base", db, 32'h10);
    endtask

    task automatic t_off();
        int de, db;
        logic seen;
        int_on = 1'b0;
        cyc(3);
        period(0, de, db);
        check("ext ref int off", de, 32'h4);
        watch(5'h02, seen);
        check("int ref held", seen, 1'b0);
        int_on = 1'b1;
        ext_on = 1'b0;
        ext_en = 1'b0;
        cyc(3);
        check("stable cleared", ext_stable, 1'b0);
        period(1, de, db);
        check("int ref ext off", db, 32'h4);
        watch(5'h05, seen);
        check("ext side held", seen, 1'b0);
    endtask

    initial
    begin
        cyc(10);
        rst_n_i = 1'b1;
        cyc(1);
        check("outputs after reset", obs, 5'h00);
        t_stab(1'b0, 1'b0);
        t_fast();
        t_inact();
        t_stab(1'b1, 1'b1);
        t_slow();
        t_off();
        finish_test();
    end
endmodule

// ==== dv/cmrd_src_model.sv ====
// Behavioural model of the external and base source clocks.
`timescale 1ns/1ps
module cmrd_src_model #(
    parameter int EXT_HALF_NS = 173,
    parameter int BASE_HALF_NS = 127
) (
    input wire logic ext_run_i, // External source running.
    output logic ext_clk_o,     // External clock.
    output logic base_clk_o     // Base clock.
);
    // The half ns offset keeps every source edge away from the system clock edges.
    initial
    begin
        base_clk_o = 1'b0;
        #0.5;
        forever #(BASE_HALF_NS) base_clk_o = ~base_clk_o;
    end
    // A dead crystal parks low, so no stray falling edge can reach the detector.
    initial
    begin
        ext_clk_o = 1'b0;
        #0.5;
        forever #(EXT_HALF_NS) ext_clk_o = ext_run_i & ~ext_clk_o;
    end
endmodule

// ==== include/cmrd_div_if.sv ====
// Connection between the reference generator and one of its divider counters.
`timescale 1ns/1ps
interface cmrd_div_if #(parameter int W = 2);
    logic tick;
    logic clr;
    logic [W-1:0] cnt;

    modport owner (output tick, output clr, input cnt);
    modport counter (input tick, input clr, output cnt);
endinterface

// ==== include/cmrd_pkg.sv ====
// Shared constants and types of the clock monitor reference divider.
package cmrd_pkg;

    // Width of the divide-by-four prescalers on both sources.
    localparam int PRE_W = 2;
    // Width of the long divider: 4096 * 4 needs fourteen stages.
    localparam int LONG_W = 14;

    // Tap positions on the long divider, counted in source falling edges.
    // Bit n toggles every 2**n edges, so it divides the source by 2**(n+1).
    localparam int EXT_NORM_BIT = 8;     // 128 * 4 = 512
    localparam int STAB_SHORT_BIT = 3;   // 16
    localparam int STAB_LONG_BIT = 11;   // 4096
    localparam int INT_REF_SHORT_BIT = 5;   // 16 * 4 = 64
    localparam int INT_REF_LONG_BIT = 13;   // 4096 * 4 = 16384

    // Prescaler tap giving divide-by-four.
    localparam int PRE_BIT = 1;

    // Consecutive empty low phases of the internal reference before inactivity.
    localparam logic [1:0] MISS_LIMIT = 2'h2;
    localparam logic [1:0] MISS_RST = 2'h0;
    localparam logic [1:0] MISS_ONE = 2'h1;

    // Reset values.
    localparam logic FLAG_RST = 1'b0;
    localparam logic REF_RST = 1'b0;

    // Source feeding the long divider.
    typedef enum logic {CMRD_SRC_EXT, CMRD_SRC_BASE} cmrd_src_t;

endpackage

// ==== verilog/cmrd_div_cnt.sv ====
// Ripple-free divider counter advanced by source edge ticks.
`timescale 1ns/1ps
module cmrd_div_cnt #(
    parameter int W = 2
) (
    input wire logic clock_i,      // System clock.
    input wire logic rst_n_i,      // Asynchronous reset, active low.
    cmrd_div_if.counter div        // Tick, clear and count.
);
    import cmrd_pkg::*;

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    generate
        if (W < 1)
        begin : g_chk
            $error("cmrd_div_cnt needs at least one stage");
        end
    endgenerate

    // Clear has priority so a source change never leaves a half-counted period.
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (div.clr)
        begin
            nxt_cnt = '0;
        end
        else if (div.tick)
        begin
            nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign div.cnt = cnt_ff;

endmodule

// ==== verilog/cmrd_ref_gen.sv ====
// Clock monitor reference generator with crystal stabilization timer.
`timescale 1ns/1ps

// Functional notes
// - While monitoring is on, the external clock is checked against the internal reference.
// - External reference comes from the external clock, internal one from the base clock.
// - Each reference runs at most half the frequency of the clock it checks.
// - Slow-crystal select and crystal enable pick which side is divided and how far.
// - Both sources feed a divide-by-four prescaler; the long divider counts the undivided source.
// - Fast crystal, stable: external ref is ext/512, internal ref is base/4.
// - Slow crystal, stable: external ref is ext/4; internal ref base/16384 or base/64.
// - Generators off force their own references low (the external one only while stable is clear), leaving the other side alone.
// - Slow crystal, stable: long divider runs on base clock; stabilization tap base/16 or /4096.
// - The long divider doubles as the crystal stabilization timer.
// - The long divider is held cleared whenever the generator enable is low.
// - After turn-on stable reads clear and the long divider runs on the external clock.
// - Stabilization clock is ext/16 without crystal, ext/4096 with crystal.
// - Stable sets on the stabilization clock falling edge, after a full count.
// - Once stable, the long divider returns to its reference duty.
// - Later stabilization edges only keep stable set, never clear it.
// - Inactivity clearing stable returns the long divider to stabilization duty.
// - Stable clears when the generator enable is low or external inactivity is flagged.
// - Inactivity sets after two internal reference low phases without external falling edge.
module cmrd_ref_gen #(
    parameter int LONG_WIDTH = cmrd_pkg::LONG_W
) (
    input wire logic clock_i,             // System clock, 20 MHz.
    input wire logic rst_n_i,             // Asynchronous reset, active low.
    input wire logic ext_clk_i,           // External clock level.
    input wire logic base_clk_i,          // Internal low-frequency base clock level.
    input wire logic int_gen_on_i,        // Internal generator on.
    input wire logic ext_gen_on_i,        // External generator on.
    input wire logic ext_gen_enable_i,    // External generator enable, low when off or stopped.
    input wire logic slow_crystal_sel_i,  // Slow-crystal select configuration bit.
    input wire logic crystal_enable_i,    // Crystal enable configuration bit.
    input wire logic monitor_on_i,        // Clock monitor enable.
    output logic ext_ref_o,               // External reference clock.
    output logic int_ref_o,               // Internal reference clock.
    output logic stab_clk_o,              // Stabilization clock.
    output logic ext_stable_o,            // External clock stable flag.
    output logic ext_inactive_o           // External clock inactive indicator.
);
    import cmrd_pkg::*;

    generate
        if (LONG_WIDTH < INT_REF_LONG_BIT + 1)
        begin : g_chk
            $error("cmrd_ref_gen long divider too short for the slowest tap");
        end
    endgenerate

    // A tap bit falls on the next tick when every bit up to it is one.
    function automatic logic tap_falls(input logic [LONG_WIDTH-1:0] cnt, input int tap);
        logic ones;
        ones = 1'b1;
        for (int i = 0; i < LONG_WIDTH; i++)
        begin
            if (i <= tap)
            begin
                ones = ones & cnt[i];
            end
        end
        return ones;
    endfunction

    // Falling edge between a sampled level and the present one.
    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction

    // Source clock sampling. Both sources must stay below half of clock_i;
    // faster external clocks cannot be seen by this sampled implementation.
    logic ext_prev_ff;
    logic base_prev_ff;
    logic ext_tick;
    logic base_tick;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_prev_ff <= REF_RST;
            base_prev_ff <= REF_RST;
        end
        else
        begin
            ext_prev_ff <= ext_clk_i;
            base_prev_ff <= base_clk_i;
        end
    end

    assign ext_tick = fell(ext_prev_ff, ext_clk_i);
    assign base_tick = fell(base_prev_ff, base_clk_i);

    // Divider counters.
    cmrd_div_if #(.W(PRE_W)) pre_ext ();
    cmrd_div_if #(.W(PRE_W)) pre_base ();
    cmrd_div_if #(.W(LONG_WIDTH)) long_div ();

    cmrd_div_cnt #(.W(PRE_W)) u_pre_ext (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .div (pre_ext.counter)
    );

    cmrd_div_cnt #(.W(PRE_W)) u_pre_base (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .div (pre_base.counter)
    );

    cmrd_div_cnt #(.W(LONG_WIDTH)) u_long (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .div (long_div.counter)
    );

    // Main state.
    cmrd_src_t long_sel_ff;
    cmrd_src_t nxt_long_sel;
    logic ext_stable_ff;
    logic nxt_ext_stable;
    logic ext_ref_ff;
    logic nxt_ext_ref;
    logic int_ref_ff;
    logic nxt_int_ref;
    logic stab_ff;
    logic nxt_stab;
    logic inactive_ff;
    logic nxt_inactive;
    logic seen_ff;
    logic nxt_seen;
    logic [1:0] miss_ff;
    logic [1:0] nxt_miss;
    logic long_tick;
    logic long_clr;
    logic stab_fall;
    logic ext_div4;
    logic base_div4;

    assign pre_ext.tick = ext_tick;
    assign pre_ext.clr = ~ext_gen_enable_i;
    assign pre_base.tick = base_tick;
    assign pre_base.clr = ~int_gen_on_i;
    assign ext_div4 = pre_ext.cnt[PRE_BIT];
    assign base_div4 = pre_base.cnt[PRE_BIT];

    assign long_div.tick = long_tick;
    assign long_div.clr = long_clr;

    always_comb
    begin
        // Long divider source: external clock until stable, base clock only
        // for a stable slow crystal.
        nxt_long_sel = CMRD_SRC_EXT;
        if (ext_stable_ff && slow_crystal_sel_i)
        begin
            nxt_long_sel = CMRD_SRC_BASE;
        end
        long_tick = (long_sel_ff == CMRD_SRC_BASE) ? base_tick : ext_tick;
        // A source change restarts the count, so no short period crosses the switch.
        // While the external clock is judged dead and stable is already gone, the
        // count is held at zero, so recovery always needs a full stabilization count.
        long_clr = ~ext_gen_enable_i | (nxt_long_sel != long_sel_ff)
                   | (inactive_ff & ~ext_stable_ff);

        // The stabilization tap sits on the long divider.
        nxt_stab = crystal_enable_i ? long_div.cnt[STAB_LONG_BIT]
                                    : long_div.cnt[STAB_SHORT_BIT];
        stab_fall = long_tick & ~long_clr & stab_ff
                    & tap_falls(long_div.cnt, crystal_enable_i ? STAB_LONG_BIT : STAB_SHORT_BIT);

        // Reference selection.
        if (!ext_stable_ff)
        begin
            nxt_ext_ref = 1'b0;
            nxt_int_ref = base_div4;
        end
        else if (slow_crystal_sel_i)
        begin
            nxt_ext_ref = ext_div4;
            nxt_int_ref = crystal_enable_i ? long_div.cnt[INT_REF_SHORT_BIT]
                                           : long_div.cnt[INT_REF_LONG_BIT];
        end
        else
        begin
            nxt_ext_ref = long_div.cnt[EXT_NORM_BIT];
            nxt_int_ref = base_div4;
        end
        if (!int_gen_on_i)
        begin
            nxt_int_ref = 1'b0;
        end
        if (!ext_gen_on_i && !ext_stable_ff)
        begin
            nxt_ext_ref = 1'b0;
            nxt_stab = 1'b0;
        end

        // Stable flag: the set wins over an inactivity clear in the same cycle.
        nxt_ext_stable = ext_stable_ff;
        if (inactive_ff)
        begin
            nxt_ext_stable = 1'b0;
        end
        if (stab_fall)
        begin
            nxt_ext_stable = 1'b1;
        end
        if (!ext_gen_enable_i)
        begin
            nxt_ext_stable = 1'b0;
        end

        // Activity check of the external clock over internal reference low phases.
        nxt_seen = seen_ff;
        nxt_miss = miss_ff;
        nxt_inactive = inactive_ff;
        if (!monitor_on_i)
        begin
            // Monitoring off: the checker rests, which is why software turns it
            // off while the reference ratios are being changed.
            nxt_seen = 1'b0;
            nxt_miss = MISS_RST;
            nxt_inactive = 1'b0;
        end
        else if (!int_ref_ff)
        begin
            if (ext_tick)
            begin
                nxt_seen = 1'b1;
                nxt_miss = MISS_RST;
                nxt_inactive = 1'b0;
            end
            else if (nxt_int_ref)
            begin
                // Low phase ends; it counts as a miss only if no external edge was seen in it.
                nxt_seen = 1'b0;
                if (!seen_ff)
                begin
                    nxt_miss = (miss_ff >= MISS_LIMIT) ? MISS_LIMIT : miss_ff + MISS_ONE;
                    if (miss_ff + MISS_ONE >= MISS_LIMIT)
                    begin
                        nxt_inactive = 1'b1;
                    end
                end
                else
                begin
                    nxt_miss = MISS_RST;
                end
            end
        end
        else
        begin
            nxt_seen = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            long_sel_ff <= CMRD_SRC_EXT;
            ext_stable_ff <= FLAG_RST;
            ext_ref_ff <= REF_RST;
            int_ref_ff <= REF_RST;
            stab_ff <= REF_RST;
            inactive_ff <= FLAG_RST;
            seen_ff <= FLAG_RST;
            miss_ff <= MISS_RST;
        end
        else
        begin
            long_sel_ff <= nxt_long_sel;
            ext_stable_ff <= nxt_ext_stable;
            ext_ref_ff <= nxt_ext_ref;
            int_ref_ff <= nxt_int_ref;
            stab_ff <= nxt_stab;
            inactive_ff <= nxt_inactive;
            seen_ff <= nxt_seen;
            miss_ff <= nxt_miss;
        end
    end

    assign ext_ref_o = ext_ref_ff;
    assign int_ref_o = int_ref_ff;
    assign stab_clk_o = stab_ff;
    assign ext_stable_o = ext_stable_ff;
    assign ext_inactive_o = inactive_ff;

endmodule
